// ---- hw/byte_count_policy.v ----
// Decision on a zero or non-zero byte count limit against the reported word 126
`timescale 1ns/100ps
`default_nettype none
`include "packet_identify_map.vh"

module byte_count_policy (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Reported behaviour word
    input wire [15:0] zeroBehaviour,
    // Command check
    input wire limitCheck,
    input wire [15:0] hostLimit,
    output reg abortCommand_reg,
    output reg limitReady_reg,
    output reg [15:0] effectiveLimit_reg
);

    wire mustAbort;

    assign mustAbort = (zeroBehaviour == 16'h0000) && (hostLimit != 16'h0000);

    always @(posedge clk) begin
        if (reset) begin
            abortCommand_reg <= 1'b0;
            limitReady_reg <= 1'b0;
            effectiveLimit_reg <= 16'h0000;
        end else begin
            abortCommand_reg <= limitCheck && mustAbort;
            limitReady_reg <= limitCheck && !mustAbort;
            if (limitCheck && !mustAbort) begin
                // A zero limit takes the reported word as the limit
                effectiveLimit_reg <= (hostLimit == 16'h0000) ? zeroBehaviour : hostLimit;
            end
        end
    end

endmodule
`default_nettype wire

// ---- hw/identify_word0_encode.v ----
// Encoder of the general configuration word, with reserved codes kept out
`timescale 1ns/100ps
`default_nettype none
`include "packet_identify_map.vh"

module identify_word0_encode (
    // Configuration
    input wire packetSupported,
    input wire [4:0] commandSetCode,
    input wire removableMedia,
    input wire fastDrq,
    input wire dataIncomplete,
    input wire packet16,
    // Encoded word
    output wire [15:0] word0
);

    wire setReserved;
    wire [4:0] setCode;
    wire [1:0] typeCode;
    wire [1:0] drqCode;
    wire [1:0] sizeCode;

    // Reserved peripheral codes are reported as unknown device type
    assign setReserved = (commandSetCode == 5'h0a) || (commandSetCode == 5'h0b) ||
                         ((commandSetCode >= 5'h10) && (commandSetCode <= 5'h1e));
    assign setCode = setReserved ? `PID_SET_UNKNOWN : commandSetCode;
    assign typeCode = packetSupported ? `PID_TYPE_PACKET : `PID_TYPE_NONE;
    assign drqCode = fastDrq ? `PID_DRQ_50US : `PID_DRQ_3MS;
    assign sizeCode = packet16 ? `PID_PKT_16B : `PID_PKT_12B;

    // Bits 13, 4 and 3 stay zero
    assign word0 = {typeCode, 1'b0, setCode, removableMedia, drqCode, 2'b00,
                    dataIncomplete, sizeCode};

endmodule
`default_nettype wire

// ---- hw/packet_identify_data.v ----
// Builder and word-by-word deliverer of the packet-device identification page
//
// What this block does
// - Word 0 bits 15:14 report 10 with packet support, 00 otherwise; never 11.
// - Word 0 bits 12:8 carry the command set code; reserved codes never reported.
// - Word 0 bit 7 is one exactly when the medium is removable.
// - Word 0 bits 6:5 give DRQ delay class: 00 is 3 ms, 10 is 50 us.
// - Word 0 bit 2 flags incomplete data; words 0 and 2 still valid.
// - Word 0 bits 1:0 give packet length: 00 twelve bytes, 01 sixteen.
// - Serial number words 10 to 19 read zero when not implemented.
// - Word 49 bit 14 flags queuing; bit 13 then also set.
// - Word 49 bit 15 flags interleaved DMA for overlapped DMA commands.
// - Word 49 bit 11 flags IORDY; forced one for PIO mode 3 up.
// - Word 49 bit 10 flags that IORDY use can be switched off.
// - Word 49 bit 9 flags LBA translation, bit 8 flags DMA.
// - Word 49 bit 12 flags the obsolete software-reset-while-busy need.
// - Word 71 holds the packet to bus release time in microseconds.
// - Word 72 holds the service to bus release time in microseconds.
// - Words 82 to 84 mirror the standard page, word 82 bit 4 set.
// - Words 85 to 87 mirror the standard page, word 85 bit 4 set.
// - Word 126 zero with non-zero host limit aborts the command.
// - Word 126 non-zero with zero host limit replaces the limit.
// - Word 126 reported value changes only across a hardware reset.
// - Word 75 bits 4:0 copy the standard queue depth field.
// - Listed standard words are copied unchanged into the page.
// - Every reserved word and bit reads zero.
`timescale 1ns/100ps
`default_nettype none
`include "packet_identify_map.vh"

module packet_identify_data (
    // Clock and reset
    input wire clk,
    input wire reset,
    // General configuration
    input wire packetSupported,
    input wire [4:0] commandSetCode,
    input wire removableMedia,
    input wire fastDrq,
    input wire dataIncomplete,
    input wire packet16,
    // Capabilities
    input wire interleavedDma,
    input wire commandQueuing,
    input wire commandOverlap,
    input wire softResetNeeded,
    input wire iordySupported,
    input wire pioMode3Plus,
    input wire iordyDisable,
    input wire lbaSupported,
    input wire dmaSupported,
    // Timing words and options
    input wire [15:0] packetReleaseUs,
    input wire [15:0] serviceReleaseUs,
    input wire serialImplemented,
    input wire [15:0] byteCountZeroCfg,
    // Standard identify page lookup
    output wire [7:0] standardIndex,
    input wire [15:0] standardWord,
    // Page delivery
    input wire pageStart,
    input wire wordRead,
    output wire pageActive,
    output reg [15:0] pageData_reg,
    output reg [7:0] wordIndex_reg,
    output reg pageDone_reg,
    // Byte count limit check
    input wire limitCheck,
    input wire [15:0] hostLimit,
    output wire abortCommand,
    output wire limitReady,
    output wire [15:0] effectiveLimit,
    output wire [15:0] reportedZeroBehaviour
);

    // ****************************************
    // State and internal signals
    // ****************************************
    localparam IDLE = 2'b01;
    localparam SEND = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [7:0] wordIndex_next;
    reg [15:0] zeroBehaviour_reg;
    reg zeroCaptured_reg;
    reg [15:0] pageWord;
    wire [15:0] word0;
    wire [15:0] word49;
    wire loadWord;
    wire lastRead;
    wire startTaken;
    wire readTaken;
    wire atLastWord;
    wire overlapFlag;
    wire iordyFlag;
    wire inSerial;
    wire inFirmwareModel;
    wire inTiming;
    wire inRevision;
    wire inFeatureTail;
    wire inUltraErase;

    // ****************************************
    // Sub-blocks
    // ****************************************
    identify_word0_encode word0Encode (
        .packetSupported(packetSupported),
        .commandSetCode(commandSetCode),
        .removableMedia(removableMedia),
        .fastDrq(fastDrq),
        .dataIncomplete(dataIncomplete),
        .packet16(packet16),
        .word0(word0)
    );

    byte_count_policy countPolicy (
        .clk(clk),
        .reset(reset),
        .zeroBehaviour(zeroBehaviour_reg),
        .limitCheck(limitCheck),
        .hostLimit(hostLimit),
        .abortCommand_reg(abortCommand),
        .limitReady_reg(limitReady),
        .effectiveLimit_reg(effectiveLimit)
    );

    // ****************************************
    // Byte count zero behaviour word
    // ****************************************
    // Captured once after each reset release; later changes of the input wait for the next reset
    always @(posedge clk) begin
        if (reset) begin
            zeroBehaviour_reg <= `PID_BCZ_RESET;
            zeroCaptured_reg <= 1'b0;
        end else if (!zeroCaptured_reg) begin
            zeroBehaviour_reg <= byteCountZeroCfg;
            zeroCaptured_reg <= 1'b1;
        end
    end

    assign reportedZeroBehaviour = zeroBehaviour_reg;

    // ****************************************
    // Capabilities word
    // ****************************************
    // Overlap follows queuing, and PIO mode 3 or above implies IORDY
    assign overlapFlag = commandOverlap | commandQueuing;
    assign iordyFlag = iordySupported | pioMode3Plus;

    assign word49 = {interleavedDma,
                     commandQueuing,
                     overlapFlag,
                     softResetNeeded,
                     iordyFlag,
                     iordyDisable,
                     lbaSupported,
                     dmaSupported,
                     8'h00};

    // ****************************************
    // Page word selection
    // ****************************************
    assign standardIndex = wordIndex_next;

    // ****************************************
    // Word ranges
    // ****************************************
    // Word 85 lies inside the feature tail but has its own case item
    assign inSerial = (wordIndex_next >= `PID_W_SERIAL_FIRST) &&
                      (wordIndex_next <= `PID_W_SERIAL_LAST);
    assign inFirmwareModel = (wordIndex_next >= `PID_W_FIRMWARE_FIRST) &&
                             (wordIndex_next <= `PID_W_MODEL_LAST);
    assign inTiming = (wordIndex_next >= `PID_W_TIMING_FIRST) &&
                      (wordIndex_next <= `PID_W_TIMING_LAST);
    assign inRevision = (wordIndex_next >= `PID_W_REV_FIRST) &&
                        (wordIndex_next < `PID_W_SUPPORTED);
    assign inFeatureTail = (wordIndex_next > `PID_W_SUPPORTED) &&
                           (wordIndex_next <= `PID_W_FEAT_LAST);
    assign inUltraErase = (wordIndex_next >= `PID_W_ULTRA) &&
                          (wordIndex_next <= `PID_W_ERASE_LAST);

    // ****************************************
    // Word multiplexer
    // ****************************************
    always @* begin
        pageWord = 16'h0000;
        case (wordIndex_next)
            `PID_W_GENCONF: begin
                pageWord = word0;
            end
            `PID_W_SPECCONF: begin
                pageWord = standardWord;
            end
            `PID_W_CAPS: begin
                pageWord = word49;
            end
            `PID_W_VALIDITY: begin
                pageWord = standardWord;
            end
            `PID_W_PACKET_REL: begin
                pageWord = packetReleaseUs;
            end
            `PID_W_SERVICE_REL: begin
                pageWord = serviceReleaseUs;
            end
            `PID_W_QUEUE: begin
                pageWord = standardWord & `PID_QUEUE_MASK;
            end
            `PID_W_SUPPORTED: begin
                pageWord = standardWord;
                pageWord[`PID_FEAT_PACKET_BIT] = 1'b1;
            end
            `PID_W_ENABLED: begin
                pageWord = standardWord;
                pageWord[`PID_FEAT_PACKET_BIT] = 1'b1;
            end
            `PID_W_RESET_RESULT: begin
                pageWord = standardWord;
            end
            `PID_W_BCZ: begin
                pageWord = zeroBehaviour_reg;
            end
            `PID_W_REMOVABLE: begin
                pageWord = standardWord;
            end
            `PID_W_SECURITY: begin
                pageWord = standardWord;
            end
            `PID_W_INTEGRITY: begin
                pageWord = standardWord;
            end
            default: begin
                // Anything outside these ranges is reserved and stays zero
                if (inSerial) begin
                    pageWord = serialImplemented ? standardWord : 16'h0000;
                end else if (inFeatureTail) begin
                    pageWord = standardWord;
                end else if (inFirmwareModel || inTiming || inRevision || inUltraErase) begin
                    pageWord = standardWord;
                end
            end
        endcase
    end

    // ****************************************
    // Delivery sequencer
    // ****************************************
    assign pageActive = state_reg[1];

    // ****************************************
    // Request qualification
    // ****************************************
    // Requests that do not fit the current state are dropped here
    assign startTaken = (state_reg == IDLE) && pageStart;
    assign readTaken = (state_reg == SEND) && wordRead;
    assign atLastWord = (wordIndex_reg == `PID_LAST_WORD);
    assign lastRead = readTaken && atLastWord;
    assign loadWord = startTaken || readTaken;

    always @* begin
        state_next = state_reg;
        wordIndex_next = wordIndex_reg;
        case (state_reg)
            IDLE: begin
                if (pageStart) begin
                    state_next = SEND;
                    wordIndex_next = `PID_W_GENCONF;
                end
            end
            SEND: begin
                if (wordRead) begin
                    // Ascending order; after word 255 the page is finished
                    wordIndex_next = wordIndex_reg + 8'h01;
                    if (atLastWord) begin
                        state_next = IDLE;
                    end
                end
            end
            default: begin
                state_next = IDLE;
                wordIndex_next = `PID_W_GENCONF;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            state_reg <= IDLE;
            wordIndex_reg <= 8'h00;
            pageData_reg <= 16'h0000;
            pageDone_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wordIndex_reg <= wordIndex_next;
            pageDone_reg <= lastRead;
            if (loadWord) begin
                pageData_reg <= pageWord;
            end
        end
    end

endmodule
`default_nettype wire

// ---- hw/packet_identify_map.vh ----
// Word indices, field positions and codes of the packet-device identification page
`ifndef PACKET_IDENTIFY_MAP_VH
`define PACKET_IDENTIFY_MAP_VH

// ****************************************
// Page geometry
// ****************************************
`define PID_PAGE_WORDS 9'h100
`define PID_LAST_WORD 8'hff

// ****************************************
// Word indices
// ****************************************
`define PID_W_GENCONF 8'h00
`define PID_W_SPECCONF 8'h02
`define PID_W_SERIAL_FIRST 8'h0a
`define PID_W_SERIAL_LAST 8'h13
`define PID_W_FIRMWARE_FIRST 8'h17
`define PID_W_MODEL_LAST 8'h2e
`define PID_W_CAPS 8'h31
`define PID_W_VALIDITY 8'h35
`define PID_W_TIMING_FIRST 8'h3f
`define PID_W_TIMING_LAST 8'h44
`define PID_W_PACKET_REL 8'h47
`define PID_W_SERVICE_REL 8'h48
`define PID_W_QUEUE 8'h4b
`define PID_W_REV_FIRST 8'h50
`define PID_W_SUPPORTED 8'h52
`define PID_W_ENABLED 8'h55
`define PID_W_FEAT_LAST 8'h57
`define PID_W_ULTRA 8'h58
`define PID_W_ERASE_LAST 8'h5a
`define PID_W_RESET_RESULT 8'h5d
`define PID_W_BCZ 8'h7e
`define PID_W_REMOVABLE 8'h7f
`define PID_W_SECURITY 8'h80
`define PID_W_INTEGRITY 8'hff

// ****************************************
// Field positions and codes
// ****************************************
`define PID_FEAT_PACKET_BIT 4
`define PID_QUEUE_MASK 16'h001f
`define PID_TYPE_PACKET 2'h2
`define PID_TYPE_NONE 2'h0
`define PID_SET_UNKNOWN 5'h1f
`define PID_DRQ_3MS 2'h0
`define PID_DRQ_50US 2'h2
`define PID_PKT_12B 2'h0
`define PID_PKT_16B 2'h1
`define PID_BCZ_RESET 16'h0000

`endif

// ---- tb/identify_page_monitor.sv ----
// Concurrent checks on page delivery and byte count decisions
`timescale 1ns/100ps
`default_nettype none
module identify_page_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Page delivery
    input wire logic pageStart,
    input wire logic wordRead,
    input wire logic pageActive,
    input wire logic [15:0] pageData_reg,
    input wire logic [7:0] wordIndex_reg,
    input wire logic pageDone_reg,
    // Byte count check
    input wire logic limitCheck,
    input wire logic [15:0] hostLimit,
    input wire logic abortCommand,
    input wire logic limitReady,
    input wire logic [15:0] effectiveLimit,
    input wire logic [15:0] reportedZeroBehaviour
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    start_opens_page_a: assert property (!pageActive && pageStart |=> pageActive && wordIndex_reg == 8'h00)
        else $error("page start did not open word 0");
    read_advances_a: assert property (pageActive && wordRead && wordIndex_reg != 8'hff
        |=> pageActive && wordIndex_reg == $past(wordIndex_reg) + 8'h01) else $error("read did not advance");
    last_read_ends_a: assert property (pageActive && wordRead && wordIndex_reg == 8'hff
        |=> pageDone_reg && !pageActive ##1 !pageDone_reg) else $error("page end wrong");
    word_holds_a: assert property (pageActive && !wordRead |=> $stable(wordIndex_reg) && $stable(pageData_reg))
        else $error("word moved without a read");
    word0_codes_a: assert property (pageActive && wordIndex_reg == 8'h00
        |-> pageData_reg[15:14] != 2'h3 && pageData_reg[6:5] != 2'h3 && !pageData_reg[1]) else $error("reserved code");
    abort_decision_a: assert property (limitCheck && reportedZeroBehaviour == 16'h0000 && hostLimit != 16'h0000
        |=> abortCommand && !limitReady) else $error("missing abort");
    limit_substitute_a: assert property (limitCheck && reportedZeroBehaviour != 16'h0000 && hostLimit == 16'h0000
        |=> limitReady && !abortCommand && effectiveLimit == $past(reportedZeroBehaviour)) else $error("no substitute");
    word126_stable_a: assert property (!$past(reset) && !$past(reset, 2) |-> $stable(reportedZeroBehaviour))
        else $error("word 126 changed without reset");
    quiet_without_check_a: assert property (!limitCheck |=> !abortCommand && !limitReady)
        else $error("answer without a check");
    cover property (pageDone_reg);
    cover property (abortCommand);
    cover property (limitReady && effectiveLimit == reportedZeroBehaviour);
endmodule
bind packet_identify_data identify_page_monitor i_mon (.clk(clk), .reset(reset), .pageStart(pageStart),
    .wordRead(wordRead), .pageActive(pageActive), .pageData_reg(pageData_reg), .wordIndex_reg(wordIndex_reg),
    .pageDone_reg(pageDone_reg), .limitCheck(limitCheck), .hostLimit(hostLimit), .abortCommand(abortCommand),
    .limitReady(limitReady), .effectiveLimit(effectiveLimit), .reportedZeroBehaviour(reportedZeroBehaviour));
`default_nettype wire

// ---- tb/standard_page_model.sv ----
// Model of the standard identify page lookup that sits beside the block
`timescale 1ns/100ps
`default_nettype none
module standard_page_model (
    // Lookup
    input wire logic [7:0] index,
    output logic [15:0] word
);
    // ****************************************
    // Lookup
    // ****************************************
    // Every word differs; bit 4 is clear in both feature words so the forced bit shows
    assign word = {index ^ 8'ha5, index ^ 8'h10};
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench of the packet identification page block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ****************************************
    // Stimulus, instances and checks
    // ****************************************
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [19:0] cfg = 20'h00000;
    logic [15:0] bcz = 16'h0200;
    logic [15:0] w126 = 16'h0200;
    logic pageStart = 1'b0;
    logic wordRead = 1'b0;
    logic limitCheck = 1'b0;
    logic [15:0] hostLimit = 16'h0000;
    wire [7:0] standardIndex;
    wire [7:0] wordIndex_reg;
    wire [15:0] standardWord, pageData_reg, effectiveLimit, reportedZeroBehaviour;
    wire pageActive, pageDone_reg, abortCommand, limitReady;
    int n_errors = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    standard_page_model i_std (.index(standardIndex), .word(standardWord));
    packet_identify_data i_dut (.clk(clk), .reset(reset), .packetSupported(cfg[0]), .commandSetCode(cfg[5:1]),
        .removableMedia(cfg[6]), .fastDrq(cfg[7]), .dataIncomplete(cfg[8]), .packet16(cfg[9]),
        .interleavedDma(cfg[10]), .commandQueuing(cfg[11]), .commandOverlap(cfg[12]), .softResetNeeded(cfg[13]),
        .iordySupported(cfg[14]), .pioMode3Plus(cfg[15]), .iordyDisable(cfg[16]), .lbaSupported(cfg[17]),
        .dmaSupported(cfg[18]), .packetReleaseUs(cfg[15:0]), .serviceReleaseUs(~cfg[15:0]),
        .serialImplemented(cfg[19]), .byteCountZeroCfg(bcz), .standardIndex(standardIndex),
        .standardWord(standardWord), .pageStart(pageStart), .wordRead(wordRead), .pageActive(pageActive),
        .pageData_reg(pageData_reg), .wordIndex_reg(wordIndex_reg), .pageDone_reg(pageDone_reg),
        .limitCheck(limitCheck), .hostLimit(hostLimit), .abortCommand(abortCommand), .limitReady(limitReady),
        .effectiveLimit(effectiveLimit), .reportedZeroBehaviour(reportedZeroBehaviour));
    function automatic logic [15:0] exp_word(input logic [7:0] i);
        logic [4:0] c;
        logic [15:0] s;
        c = cfg[5:1];
        s = {i ^ 8'ha5, i ^ 8'h10};
        if (c == 5'h0a || c == 5'h0b || (c >= 5'h10 && c != 5'h1f))
            c = 5'h1f;
        case (i) inside
            8'h00: exp_word = {cfg[0], 2'h0, c, cfg[6], cfg[7], 3'h0, cfg[8], 1'b0, cfg[9]};
            8'h31: exp_word = {cfg[10], cfg[11], cfg[11] | cfg[12], cfg[13], cfg[14] | cfg[15],
                               cfg[16], cfg[17], cfg[18], 8'h00};
            8'h47: exp_word = cfg[15:0];
            8'h48: exp_word = ~cfg[15:0];
            8'h4b: exp_word = s & 16'h001f;
            8'h52, 8'h55: exp_word = s | 16'h0010;
            8'h7e: exp_word = w126;
            [8'h0a:8'h13]: exp_word = cfg[19] ? s : 16'h0000;
            8'h02, [8'h17:8'h2e], 8'h35, [8'h3f:8'h44], 8'h50, 8'h51, 8'h53, 8'h54, [8'h56:8'h5a], 8'h5d, 8'h7f,
            8'h80, 8'hff: exp_word = s;
            default: exp_word = 16'h0000;
        endcase
    endfunction
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic do_reset(input logic [15:0] value);
        reset = 1'b1;
        bcz = value;
        repeat (16) step();
        reset = 1'b0;
        w126 = value;
        step();
        wordRead = 1'b1;
        step();
        wordRead = 1'b0;
        chk(pageActive === 1'b0 && wordIndex_reg === 8'h00, "read while idle moved the page");
        chk(reportedZeroBehaviour === value, "word 126 not captured");
    endtask
    task automatic read_page(input logic [19:0] c);
        cfg = c;
        pageStart = 1'b1;
        step();
        for (int i = 0; i < 256; i++) begin
            chk(pageActive === 1'b1 && wordIndex_reg === i[7:0], "word index off");
            chk(pageData_reg === exp_word(i[7:0]), $sformatf("word %0d wrong", i));
            // A pause in the reads must hold the word
            if (i == 7) begin
                wordRead = 1'b0;
                step();
                chk(wordIndex_reg === 8'h07 && pageData_reg === exp_word(8'h07), "word moved without a read");
            end
            // A start in mid-page must be ignored
            pageStart = (i == 5);
            wordRead = 1'b1;
            step();
        end
        wordRead = 1'b0;
        chk(pageDone_reg === 1'b1 && pageActive === 1'b0, "page did not end");
        step();
        chk(pageDone_reg === 1'b0, "done is not a pulse");
    endtask
    task automatic limit(input logic [15:0] h, input logic ab, input logic [15:0] eff);
        hostLimit = h;
        limitCheck = 1'b1;
        step();
        limitCheck = 1'b0;
        chk(abortCommand === ab && limitReady === ~ab, "wrong abort decision");
        chk(ab || effectiveLimit === eff, "wrong effective limit");
        step();
        chk(abortCommand === 1'b0 && limitReady === 1'b0, "answer is not a pulse");
    endtask
    task automatic summarize();
        $display("checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        do_reset(16'h0200);
        read_page(20'h5a815);
        read_page(20'ha57ea);
        limit(16'h0000, 1'b0, 16'h0200);
        limit(16'h0040, 1'b0, 16'h0040);
        bcz = 16'h0000;
        read_page(20'h3f80b);
        do_reset(16'h0000);
        limit(16'h0010, 1'b1, 16'h0000);
        limit(16'h0000, 1'b0, 16'h0000);
        summarize();
    end
    initial begin
        #40000;
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
